// *** udreg_top.sv ***
// Purpose: Register bank of the UART: normal, divisor and enhanced banks
// Assumes: Host strobes synchronous to clk, one-cycle pulses
// Notes: Read data is registered one cycle after the read strobe
// Summary of operation
// [RULE1] Extended bits write and act only while enhanced enable is set
// [RULE2] Enhanced enable unlocks interrupt, FIFO, modem and fraction fields
// [RULE3] Divisor bank: address 0 accesses divisor low byte
// [RULE4] Address 1 accesses divisor high byte in the divisor bank
// [RULE5] Address 2 holds 4-bit fraction, upper bits zero, needs enhanced enable
// [RULE6] Divisor bank, divisor zero: address 0 reads the revision
// [RULE7] Divisor zero, not enhanced key: address 1 reads the identity code
// [RULE8] Enhanced bank write at address 0 loads the trigger level
// [RULE9] Enhanced bank read at address 0 returns FIFO level count
// [RULE10] Feature control at address 1 holds mode, swap, table, invert, hysteresis
// [RULE11] Enhanced function at address 2 only under key 0xBF
// [RULE12] Addresses 4 to 7 hold resume and pause characters
// [RULE13] Receive holding is read only; writes leave received data alone
// [RULE14] Transmit holding is write only; reads there return receive data
// [RULE15] Enhanced bank only while line control holds 0xBF
// [RULE16] Enhanced address 0 reads FIFO level, writes trigger level
// [RULE17] Selection uses address, bank key and enable; blocked access changes nothing
`timescale 1ns/1ps
`default_nettype none
`include "udreg_map.svh"
module udreg_top (
  input wire logic clk, // System clock
  input wire logic reset_n, // Asynchronous reset, active low
  input wire logic [2:0] reg_addr, // Register address
  input wire logic wr_strobe, // Write pulse
  input wire logic rd_strobe, // Read pulse
  input wire logic [7:0] wr_data, // Write data
  input wire logic [7:0] rx_data, // Received character from receiver
  input wire logic [7:0] fifo_level, // FIFO level from FIFO logic
  output logic [7:0] rd_data, // Registered read data
  output logic [7:0] tx_data, // Transmit character
  output logic tx_load, // Transmit write pulse
  output logic [7:0] line_control, // Line control register
  output logic [15:0] baud_divisor, // Divisor high:low
  output logic [3:0] baud_fraction, // Effective fractional divisor
  output logic [7:0] interrupt_enable, // Effective interrupt enable
  output logic [7:0] fifo_control, // Effective FIFO control
  output logic [7:0] modem_control, // Effective modem control
  output logic [7:0] fifo_trigger, // Trigger level
  output udreg_pkg::udreg_feature_type features, // Feature control
  output udreg_pkg::udreg_enhanced_type enhanced, // Enhanced function
  output udreg_pkg::udreg_flow_chars_type flow_chars // Flow characters
);
  udreg_pkg::udreg_bank_type bank;
  logic [7:0] divisor_low_reg;
  logic [7:0] divisor_high_reg;
  logic [3:0] fraction_reg;
  logic [7:0] line_control_reg;
  logic [7:0] interrupt_enable_reg;
  logic [7:0] fifo_control_reg;
  logic [7:0] modem_control_reg;
  logic [7:0] scratch_reg;
  logic [7:0] trigger_reg;
  logic [7:0] tx_data_reg;
  logic tx_load_reg;
  udreg_pkg::udreg_feature_type feature_reg;
  udreg_pkg::udreg_enhanced_type enhanced_reg;
  logic [7:0] rd_data_reg;
  logic [7:0] rd_data_next;
  logic chars_wr;
  logic enh_on;
  logic divisor_zero;
  logic in_div;
  logic in_enh;
  logic [7:0] ie_mask;
  logic [7:0] fc_mask;
  logic [7:0] mc_mask;

  udreg_decode u_decode (
    .clk(clk),
    .reset_n(reset_n),
    .line_control(line_control_reg),
    .bank(bank)
  );

  assign in_enh = bank == udreg_pkg::UDREG_BANK_ENHANCED; // see [RULE15]
  assign in_div = bank == udreg_pkg::UDREG_BANK_DIVISOR;
  assign enh_on = enhanced_reg.enhanced_enable; // see [RULE1]
  assign divisor_zero = divisor_low_reg == `UDREG_RESET_BYTE &&
    divisor_high_reg == `UDREG_RESET_BYTE;
  assign ie_mask = enh_on ? 8'hFF : ~`UDREG_IE_ENH_MASK; // see [RULE2]
  assign fc_mask = enh_on ? 8'hFF : ~`UDREG_FC_ENH_MASK; // see [RULE2]
  assign mc_mask = enh_on ? 8'hFF : ~`UDREG_MC_ENH_MASK; // see [RULE2]
  assign chars_wr = wr_strobe && in_enh && reg_addr[2]; // see [RULE12]

  udreg_flow_chars u_chars (
    .clk(clk),
    .reset_n(reset_n),
    .wr_en(chars_wr),
    .wr_sel(reg_addr[1:0]),
    .wr_data(wr_data),
    .rd_sel(reg_addr[1:0]),
    .rd_data(),
    .chars(flow_chars)
  );

  // Line control is reachable in every bank, the enhanced one included
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      line_control_reg <= `UDREG_LC_RESET;
    else if (wr_strobe && reg_addr == `UDREG_ADDR_3)
      line_control_reg <= wr_data;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      divisor_low_reg <= `UDREG_RESET_BYTE;
    else if (wr_strobe && in_div && reg_addr == `UDREG_ADDR_0)
      divisor_low_reg <= wr_data; // see [RULE3]
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      divisor_high_reg <= `UDREG_RESET_BYTE;
    else if (wr_strobe && in_div && reg_addr == `UDREG_ADDR_1)
      divisor_high_reg <= wr_data; // see [RULE4]
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      fraction_reg <= 4'h0;
    else if (wr_strobe && in_div && enh_on && reg_addr == `UDREG_ADDR_2)
      fraction_reg <= wr_data[3:0]; // see [RULE5]
  end

  // Extended bits keep their old value when the enable is off
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      interrupt_enable_reg <= `UDREG_RESET_BYTE;
    else if (wr_strobe && bank == udreg_pkg::UDREG_BANK_NORMAL &&
             reg_addr == `UDREG_ADDR_1)
      interrupt_enable_reg <= (wr_data & ie_mask) |
        (interrupt_enable_reg & ~ie_mask); // see [RULE1]
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      fifo_control_reg <= `UDREG_RESET_BYTE;
    else if (wr_strobe && !in_enh && reg_addr == `UDREG_ADDR_2 && !in_div)
      fifo_control_reg <= (wr_data & fc_mask) |
        (fifo_control_reg & ~fc_mask); // see [RULE1]
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      modem_control_reg <= `UDREG_RESET_BYTE;
    else if (wr_strobe && !in_enh && reg_addr == `UDREG_ADDR_4)
      modem_control_reg <= (wr_data & mc_mask) |
        (modem_control_reg & ~mc_mask); // see [RULE1]
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      scratch_reg <= `UDREG_RESET_BYTE;
    else if (wr_strobe && !in_enh && reg_addr == `UDREG_ADDR_7 &&
             !feature_reg.scratch_swap)
      scratch_reg <= wr_data;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      trigger_reg <= `UDREG_RESET_BYTE;
    else if (wr_strobe && in_enh && reg_addr == `UDREG_ADDR_0)
      trigger_reg <= wr_data; // see [RULE8] [RULE16]
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      feature_reg <= '0;
    else if (wr_strobe && in_enh && reg_addr == `UDREG_ADDR_1)
      feature_reg <= wr_data; // see [RULE10]
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      enhanced_reg <= '0;
    else if (wr_strobe && in_enh && reg_addr == `UDREG_ADDR_2)
      enhanced_reg <= wr_data; // see [RULE11]
  end

  // Transmit path only; received data is never written by the host
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      tx_load_reg <= 1'b0;
    else
      tx_load_reg <= wr_strobe && bank == udreg_pkg::UDREG_BANK_NORMAL &&
        reg_addr == `UDREG_ADDR_0; // see [RULE13] [RULE14]
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      tx_data_reg <= `UDREG_RESET_BYTE;
    else if (wr_strobe && bank == udreg_pkg::UDREG_BANK_NORMAL &&
             reg_addr == `UDREG_ADDR_0)
      tx_data_reg <= wr_data; // see [RULE14]
  end

  always_comb
  begin
    rd_data_next = `UDREG_RESET_BYTE;
    if (in_enh)
    begin
      if (reg_addr == `UDREG_ADDR_0)
        rd_data_next = fifo_level; // see [RULE9] [RULE16]
      else if (reg_addr == `UDREG_ADDR_1)
        rd_data_next = feature_reg; // see [RULE10]
      else if (reg_addr == `UDREG_ADDR_2)
        rd_data_next = enhanced_reg; // see [RULE11]
      else if (reg_addr == `UDREG_ADDR_3)
        rd_data_next = line_control_reg;
      // Characters come straight from their flops so a read sees this address
      else if (reg_addr == `UDREG_ADDR_4)
        rd_data_next = flow_chars.resume_first; // see [RULE12]
      else if (reg_addr == `UDREG_ADDR_5)
        rd_data_next = flow_chars.resume_second;
      else if (reg_addr == `UDREG_ADDR_6)
        rd_data_next = flow_chars.pause_first;
      else
        rd_data_next = flow_chars.pause_second;
    end
    else if (in_div && reg_addr == `UDREG_ADDR_0)
      rd_data_next = divisor_zero ? `UDREG_DEVICE_REVISION
        : divisor_low_reg; // see [RULE3] [RULE6]
    else if (in_div && reg_addr == `UDREG_ADDR_1)
      rd_data_next = divisor_zero ? `UDREG_DEVICE_IDENTITY
        : divisor_high_reg; // see [RULE4] [RULE7]
    else if (in_div && reg_addr == `UDREG_ADDR_2)
      rd_data_next = enh_on ? {4'h0, fraction_reg}
        : `UDREG_RESET_BYTE; // see [RULE5]
    else if (reg_addr == `UDREG_ADDR_0)
      rd_data_next = rx_data; // see [RULE13] [RULE14]
    else if (reg_addr == `UDREG_ADDR_1)
      rd_data_next = interrupt_enable_reg & ie_mask; // see [RULE2]
    else if (reg_addr == `UDREG_ADDR_3)
      rd_data_next = line_control_reg;
    else if (reg_addr == `UDREG_ADDR_4)
      rd_data_next = modem_control_reg & mc_mask; // see [RULE2]
    else if (reg_addr == `UDREG_ADDR_7)
      rd_data_next = feature_reg.scratch_swap ? fifo_level : scratch_reg;
    else
      rd_data_next = `UDREG_RESET_BYTE;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      rd_data_reg <= `UDREG_RESET_BYTE;
    else if (rd_strobe)
      rd_data_reg <= rd_data_next;
  end

  // Effective views: extended fields forced inactive without the enable
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      interrupt_enable <= `UDREG_RESET_BYTE;
    else
      interrupt_enable <= interrupt_enable_reg & ie_mask; // see [RULE1]
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      fifo_control <= `UDREG_RESET_BYTE;
    else
      fifo_control <= fifo_control_reg & fc_mask; // see [RULE2]
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      modem_control <= `UDREG_RESET_BYTE;
    else
      modem_control <= modem_control_reg & mc_mask; // see [RULE2]
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      baud_fraction <= 4'h0;
    else
      baud_fraction <= enh_on ? fraction_reg : 4'h0; // see [RULE5]
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      line_control <= `UDREG_LC_RESET;
    else
      line_control <= line_control_reg;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      baud_divisor <= 16'h0000;
    else
      baud_divisor <= {divisor_high_reg, divisor_low_reg};
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      fifo_trigger <= `UDREG_RESET_BYTE;
    else
      fifo_trigger <= trigger_reg;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      features <= '0;
    else
      features <= feature_reg;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      enhanced <= '0;
    else
      enhanced <= enhanced_reg;
  end

  assign rd_data = rd_data_reg;
  assign tx_data = tx_data_reg;
  assign tx_load = tx_load_reg;
endmodule : udreg_top
`default_nettype wire

// *** udreg_map.svh ***
// Purpose: Offsets, keys, field positions and reset values of the register bank
// Assumes: 3-bit register address, 8-bit data
// Notes: Definitions only
`ifndef UDREG_MAP_SVH
`define UDREG_MAP_SVH
`define UDREG_ADDR_0 3'h0
`define UDREG_ADDR_1 3'h1
`define UDREG_ADDR_2 3'h2
`define UDREG_ADDR_3 3'h3
`define UDREG_ADDR_4 3'h4
`define UDREG_ADDR_5 3'h5
`define UDREG_ADDR_6 3'h6
`define UDREG_ADDR_7 3'h7
`define UDREG_ENH_KEY 8'hBF
`define UDREG_LC_DIV_BIT 7
`define UDREG_EF_ENH_BIT 4
`define UDREG_FRAC_MASK 8'h0F
`define UDREG_RESET_BYTE 8'h00
`define UDREG_LC_RESET 8'h03
`define UDREG_DEVICE_REVISION 8'h01
`define UDREG_DEVICE_IDENTITY 8'h5C
`define UDREG_IE_ENH_MASK 8'hF0
`define UDREG_FC_ENH_MASK 8'h30
`define UDREG_MC_ENH_MASK 8'hE0
`define UDREG_IS_ENH_MASK 8'h30
`endif

// *** udreg_pkg.sv ***
// Purpose: Types shared by the register bank
// Assumes: Constants live in udreg_map.svh
// Notes: None
package udreg_pkg;
  typedef enum logic [1:0] {
    UDREG_BANK_NORMAL = 2'b00,
    UDREG_BANK_DIVISOR = 2'b01,
    UDREG_BANK_ENHANCED = 2'b10
  } udreg_bank_type;
  typedef struct packed {
    logic rx_tx_mode;
    logic scratch_swap;
    logic [1:0] trigger_table;
    logic reserved;
    logic ir_invert;
    logic [1:0] rts_hysteresis;
  } udreg_feature_type;
  typedef struct packed {
    logic auto_cts;
    logic auto_rts;
    logic special_char;
    logic enhanced_enable;
    logic [3:0] soft_flow;
  } udreg_enhanced_type;
  typedef struct packed {
    logic [7:0] resume_first;
    logic [7:0] resume_second;
    logic [7:0] pause_first;
    logic [7:0] pause_second;
  } udreg_flow_chars_type;
endpackage : udreg_pkg

// *** udreg_decode.sv ***
// Purpose: Picks the register bank from the line control value alone
// Assumes: Line control comes from a register
// Notes: Registered bank selection
`timescale 1ns/1ps
`default_nettype none
`include "udreg_map.svh"
module udreg_decode (
  input wire logic clk, // System clock
  input wire logic reset_n, // Asynchronous reset, active low
  input wire logic [7:0] line_control, // Current line control value
  output udreg_pkg::udreg_bank_type bank // Selected bank
);
  udreg_pkg::udreg_bank_type bank_next;
  always_comb
  begin
    if (line_control == `UDREG_ENH_KEY)
      bank_next = udreg_pkg::UDREG_BANK_ENHANCED; // see [RULE15]
    else if (line_control[`UDREG_LC_DIV_BIT])
      bank_next = udreg_pkg::UDREG_BANK_DIVISOR; // see [RULE17]
    else
      bank_next = udreg_pkg::UDREG_BANK_NORMAL;
  end
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      bank <= udreg_pkg::UDREG_BANK_NORMAL;
    else
      bank <= bank_next;
  end
endmodule : udreg_decode
`default_nettype wire

// *** udreg_flow_chars.sv ***
// Purpose: Holds the four flow-control characters
// Assumes: Write strobe qualified by the enhanced bank
// Notes: One generate loop over entries
`timescale 1ns/1ps
`default_nettype none
`include "udreg_map.svh"
module udreg_flow_chars (
  input wire logic clk, // System clock
  input wire logic reset_n, // Asynchronous reset, active low
  input wire logic wr_en, // Write to a character slot
  input wire logic [1:0] wr_sel, // Slot 0..3
  input wire logic [7:0] wr_data, // Written character
  input wire logic [1:0] rd_sel, // Slot to read
  output logic [7:0] rd_data, // Registered read data
  output udreg_pkg::udreg_flow_chars_type chars // All four slots
);
  logic [7:0] slot_reg [4];
  genvar i;
  generate
    for (i = 0; i < 4; i++)
    begin : g_slot
      always_ff @(posedge clk or negedge reset_n)
      begin
        if (!reset_n)
          slot_reg[i] <= `UDREG_RESET_BYTE;
        else if (wr_en && wr_sel == 2'(i))
          slot_reg[i] <= wr_data; // see [RULE12]
      end
    end
  endgenerate
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      rd_data <= `UDREG_RESET_BYTE;
    else
      rd_data <= slot_reg[rd_sel];
  end
  assign chars = {slot_reg[0], slot_reg[1], slot_reg[2], slot_reg[3]};
endmodule : udreg_flow_chars
`default_nettype wire

// *** udreg_properties.sv ***
// Purpose: Concurrent checks on the register bank ports
// Assumes: One clock domain, reset_n asynchronous active low
// Notes: Bound to udreg_top below the module
`timescale 1ns/1ps
`default_nettype none
module udreg_properties (
  input wire logic clk, // System clock
  input wire logic reset_n, // Reset, active low
  input wire logic [2:0] reg_addr, // Register address
  input wire logic wr_strobe, // Write pulse
  input wire logic rd_strobe, // Read pulse
  input wire logic [7:0] wr_data, // Write data
  input wire logic [7:0] rd_data, // Read data
  input wire logic [7:0] tx_data, // Transmit character
  input wire logic tx_load, // Transmit pulse
  input wire logic [15:0] baud_divisor, // Divisor
  input wire logic [3:0] baud_fraction, // Fraction
  input wire logic [7:0] interrupt_enable, // Interrupt enable
  input wire logic [7:0] fifo_control, // FIFO control
  input wire logic [7:0] modem_control, // Modem control
  input wire logic [7:0] fifo_trigger, // Trigger level
  input wire udreg_pkg::udreg_feature_type features, // Feature control
  input wire udreg_pkg::udreg_enhanced_type enhanced, // Enhanced function
  input wire udreg_pkg::udreg_flow_chars_type flow_chars // Flow chars
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  chk_tx_source: assert property (tx_load |-> $past(wr_strobe) &&
    $past(reg_addr) == 3'h0) else $error("tx_load without write");
  chk_tx_value: assert property (tx_load |-> tx_data == $past(wr_data))
    else $error("tx_data differs from written byte");
  chk_frac_gate: assert property (!enhanced.enhanced_enable [*3] |->
    baud_fraction == 4'h0) else $error("fraction active while locked");
  chk_ie_mask: assert property (!enhanced.enhanced_enable [*3] |->
    interrupt_enable[7:4] == 4'h0) else $error("ie upper bits active");
  chk_fifo_mask: assert property (!enhanced.enhanced_enable [*3] |->
    fifo_control[5:4] == 2'h0) else $error("fifo ctl bits active");
  chk_modem_mask: assert property (!enhanced.enhanced_enable [*3] |->
    modem_control[7:5] == 3'h0) else $error("modem bits active");
  chk_div_hold: assert property (!wr_strobe [*3] |=> $stable(baud_divisor))
    else $error("divisor changed without write");
  chk_chars_hold: assert property (!wr_strobe [*3] |=> $stable(flow_chars))
    else $error("flow chars changed without write");
  chk_feat_hold: assert property (!wr_strobe [*3] |=>
    $stable(features) && $stable(enhanced)) else $error("feature changed");
  chk_trig_hold: assert property (!wr_strobe [*3] |=> $stable(fifo_trigger))
    else $error("trigger changed without write");
  chk_rd_hold: assert property (!rd_strobe [*2] |=> $stable(rd_data))
    else $error("rd_data changed without read");
endmodule : udreg_properties
bind udreg_top udreg_properties chk (
  .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .wr_strobe(wr_strobe),
  .rd_strobe(rd_strobe), .wr_data(wr_data), .rd_data(rd_data),
  .tx_data(tx_data), .tx_load(tx_load), .baud_divisor(baud_divisor),
  .baud_fraction(baud_fraction), .interrupt_enable(interrupt_enable),
  .fifo_control(fifo_control), .modem_control(modem_control),
  .fifo_trigger(fifo_trigger), .features(features), .enhanced(enhanced),
  .flow_chars(flow_chars)
);
`default_nettype wire

// *** udreg_host_model.sv ***
// Purpose: Host processor driving the register strobes
// Assumes: Strobes change 1 ns after the rising edge
// Notes: Released write data is inverted so stale values never match
`timescale 1ns/1ps
`default_nettype none
module udreg_host_model (
  input wire logic clk, // Bus clock
  output logic [2:0] reg_addr, // Register address
  output logic wr_strobe, // Write pulse
  output logic rd_strobe, // Read pulse
  output logic [7:0] wr_data // Write data
);
  initial
  begin
    reg_addr = 3'h0;
    wr_strobe = 1'b0;
    rd_strobe = 1'b0;
    wr_data = 8'h00;
  end
  task automatic write(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    reg_addr = a;
    wr_data = d;
    wr_strobe = 1'b1;
    @(posedge clk);
    #1;
    wr_strobe = 1'b0;
    wr_data = ~d;
  endtask : write
  task automatic read(input logic [2:0] a);
    @(posedge clk);
    #1;
    reg_addr = a;
    rd_strobe = 1'b1;
    @(posedge clk);
    #1;
    rd_strobe = 1'b0;
  endtask : read
endmodule : udreg_host_model
`default_nettype wire

// *** tb_top.sv ***
// Purpose: Self-checking bench for the register bank
// Assumes: Bank switch settles within three cycles
// Notes: Read results are checked from a queue by a monitor
`timescale 1ns/1ps
`default_nettype none
`include "udreg_map.svh"
`define UDTB_CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) \
  begin mismatches++; $display("[ERR] %s exp %h got %h", nm, ex, got); end end
module tb_top;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] rx_data = 8'h00;
  logic [7:0] fifo_level = 8'h00;
  wire [2:0] reg_addr;
  wire wr_strobe;
  wire rd_strobe;
  wire [7:0] wr_data;
  logic [7:0] rd_data, tx_data, line_control, interrupt_enable;
  logic [7:0] fifo_control, modem_control, fifo_trigger;
  logic tx_load;
  logic [15:0] baud_divisor;
  logic [3:0] baud_fraction;
  udreg_pkg::udreg_feature_type features;
  udreg_pkg::udreg_enhanced_type enhanced;
  udreg_pkg::udreg_flow_chars_type flow_chars;
  int mismatches = 0;
  int samples_checked = 0;
  int cycles = 0;
  int tx_loads = 0;
  logic [7:0] expq[$];
  logic rd_taken = 1'b0;
  logic [7:0] lo, hi, ef, ft, tl, tc, exp_rd;
  logic [7:0] ch[4];
  udreg_host_model host (.clk(clk), .reg_addr(reg_addr),
    .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .wr_data(wr_data));
  udreg_top uut (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .wr_data(wr_data),
    .rx_data(rx_data), .fifo_level(fifo_level), .rd_data(rd_data),
    .tx_data(tx_data), .tx_load(tx_load), .line_control(line_control),
    .baud_divisor(baud_divisor), .baud_fraction(baud_fraction),
    .interrupt_enable(interrupt_enable), .fifo_control(fifo_control),
    .modem_control(modem_control), .fifo_trigger(fifo_trigger),
    .features(features), .enhanced(enhanced), .flow_chars(flow_chars));
  initial
  begin
    forever #5 clk = ~clk;
  end
  task automatic conclude;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : conclude
  always @(posedge clk)
  begin
    cycles++;
    if (tx_load === 1'b1)
      tx_loads++;
    if (cycles == 5000)
    begin
      mismatches++;
      conclude();
    end
  end
  // Monitor: a read result appears on the same edge that takes the strobe
  always @(posedge clk) rd_taken <= rd_strobe;
  always @(negedge clk)
  begin
    if (rd_taken === 1'b1)
    begin
      if (expq.size() == 0)
      begin
        mismatches++;
        $display("[ERR] rd_data exp none got %h", rd_data);
      end
      else
      begin
        exp_rd = expq.pop_front();
        `UDTB_CHK("rd_data", exp_rd, rd_data)
      end
    end
  end
  task automatic rd(input logic [2:0] a, input logic [7:0] ex);
    expq.push_back(ex);
    host.read(a);
  endtask : rd
  task automatic settle;
    repeat (3) @(posedge clk);
    #1;
  endtask : settle
  task automatic set_lc(input logic [7:0] v);
    host.write(`UDREG_ADDR_3, v);
    settle();
  endtask : set_lc
  initial
  begin
    void'($urandom(32'h0202));
    repeat (16) @(posedge clk);
    #1;
    reset_n = 1'b1;
    `UDTB_CHK("line_control", `UDREG_LC_RESET, line_control)
    `UDTB_CHK("baud_divisor", 16'h0000, baud_divisor)
    $display("test reset done");
    set_lc(8'h80);
    rd(3'h0, `UDREG_DEVICE_REVISION);
    rd(3'h1, `UDREG_DEVICE_IDENTITY);
    lo = 8'($urandom_range(255, 1));
    hi = 8'($urandom());
    host.write(3'h0, lo);
    host.write(3'h1, hi);
    host.write(3'h2, 8'hFF);
    rd(3'h0, lo);
    rd(3'h1, hi);
    settle();
    `UDTB_CHK("baud_fraction", 4'h0, baud_fraction)
    $display("test divisor bank done");
    set_lc(`UDREG_ENH_KEY);
    ef = 8'($urandom()) | 8'h10;
    ft = 8'($urandom()) & 8'hF7;
    tl = 8'($urandom());
    fifo_level = 8'($urandom());
    host.write(3'h2, ef);
    host.write(3'h1, ft);
    host.write(3'h0, tl);
    rd(3'h2, ef);
    rd(3'h1, ft);
    rd(3'h0, fifo_level);
    for (int i = 0; i < 4; i++)
    begin
      ch[i] = 8'($urandom());
      host.write(3'(4 + i), ch[i]);
    end
    for (int i = 0; i < 4; i++)
      rd(3'(4 + i), ch[i]);
    settle();
    `UDTB_CHK("fifo_trigger", tl, fifo_trigger)
    `UDTB_CHK("baud_divisor", {hi, lo}, baud_divisor)
    `UDTB_CHK("flow_chars", {ch[0], ch[1], ch[2], ch[3]}, flow_chars)
    `UDTB_CHK("features", ft, features)
    `UDTB_CHK("enhanced", ef, enhanced)
    $display("test enhanced bank done");
    set_lc(8'h80);
    host.write(3'h2, 8'hA7);
    rd(3'h2, 8'h07);
    settle();
    `UDTB_CHK("baud_fraction", 4'h7, baud_fraction)
    $display("test fraction done");
    set_lc(8'h03);
    rx_data = 8'($urandom());
    tc = 8'($urandom());
    host.write(3'h0, tc);
    rd(3'h0, rx_data);
    host.write(3'h1, 8'hFF);
    host.write(3'h2, 8'hFF);
    host.write(3'h4, 8'hFF);
    host.write(3'h5, ~ch[1]);
    settle();
    `UDTB_CHK("tx_data", tc, tx_data)
    `UDTB_CHK("interrupt_enable", 8'hFF, interrupt_enable)
    `UDTB_CHK("fifo_control", 2'h3, fifo_control[5:4])
    `UDTB_CHK("modem_control", 3'h7, modem_control[7:5])
    `UDTB_CHK("flow_chars", {ch[0], ch[1], ch[2], ch[3]}, flow_chars)
    set_lc(`UDREG_ENH_KEY);
    host.write(3'h2, ef & 8'hEF);
    set_lc(8'h03);
    host.write(3'h1, 8'h00);
    settle();
    `UDTB_CHK("interrupt_enable", 8'h00, interrupt_enable)
    `UDTB_CHK("baud_fraction", 4'h0, baud_fraction)
    `UDTB_CHK("modem_control", 8'h1F, modem_control)
    `UDTB_CHK("fifo_control", 8'hCF, fifo_control)
    rd(3'h4, 8'h1F);
    set_lc(`UDREG_ENH_KEY);
    host.write(3'h2, ef);
    set_lc(8'h03);
    `UDTB_CHK("interrupt_enable", 8'hF0, interrupt_enable)
    `UDTB_CHK("tx_load count", 1, tx_loads)
    $display("test normal bank done");
    conclude();
  end
endmodule : tb_top
`default_nettype wire
